// ---- rtl/vgc_core.sv ----
// Operation
// RL1 - Correct only points already reduced by centroiding
// RL2 - Find cell, normalize, interpolate four corners
// RL3 - t is x offset over horizontal spacing
// RL4 - Bilinear weighted corner sum, divided by 16
// RL5 - Keep x, output y plus correction
// RL6 - Above 95%: lower corners count as zero
// RL7 - Below 5%: upper corners count as zero
// RL8 - Constants held and read as signed 16-bit
// RL9 - Constants are sixteen times true LSB correction
// RL10 - Row-major table, 29 per row, 5%..95%
// RL11 - Fixed column positions on 1024-point record
// RL12 - Halve positions for 512, quarter for 256
// RL13 - Last column maps to final record point
// RL14 - Correction switchable; off passes points unchanged
// RL15 - Characterization start shows running until done
// RL16 - Host re-characterizes after window or length change
// RL17 - Subtract reference defects from target when enabled
// RL18 - Defect voids flagged for centroid gap filling
// RL19 - Host can read back the defect list
// RL20 - Never alter stored target image data
// RL21 - Table is ten rows by 29 columns
// RL22 - Fixed point, round correction to nearest LSB
// RL23 - Out-of-range points use nearest edge cell
`timescale 1ns/100ps
`include "vgc_consts.svh"
module vgc_core #(
    parameter int X_W = 10,
    parameter int Y_W = 11,
    parameter int Z_W = 8,
    parameter int DEF_N = 8,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic corr_en,
    input wire vgc_pkg::vgc_len_t len_sel,
    input wire logic pt_valid,
    output logic pt_ready,
    input wire logic [X_W-1:0] pt_x,
    input wire logic [Y_W-1:0] pt_y,
    output logic out_valid_ff,
    input wire logic out_ready,
    output logic [X_W-1:0] out_x_ff,
    output logic [Y_W-1:0] out_y_ff,
    input wire logic cal_start,
    input wire logic cal_done,
    input wire logic cal_wr,
    input wire logic [8:0] cal_addr,
    input wire logic signed [15:0] cal_data,
    output logic acq_running_ff,
    input wire logic tbl_rd_req,
    input wire logic [8:0] tbl_rd_addr,
    output logic tbl_rd_valid_ff,
    output logic signed [15:0] tbl_rd_data_ff,
    input wire logic defect_en,
    input wire logic def_clear,
    input wire logic def_wr,
    input wire logic [$clog2(DEF_N)-1:0] def_idx,
    input wire logic [X_W-1:0] def_x,
    input wire logic [Y_W-1:0] def_y,
    input wire logic def_rd_req,
    input wire logic [$clog2(DEF_N)-1:0] def_rd_idx,
    output logic def_rd_valid_ff,
    output logic def_rd_hit_ff,
    output logic [X_W-1:0] def_rd_x_ff,
    output logic [Y_W-1:0] def_rd_y_ff,
    input wire logic tgt_valid,
    input wire logic [X_W-1:0] tgt_line,
    input wire logic [Y_W-1:0] tgt_row,
    input wire logic [Z_W-1:0] tgt_charge,
    output logic tgt_valid_ff,
    output logic [Z_W-1:0] tgt_charge_ff,
    output logic tgt_void_ff
);
    localparam int FS = 1 << Y_W;
    localparam int PW = X_W + Y_W;

    function automatic logic [10:0] col_pos(input int i);
        if (i <= `VGC_GAP1_COL - 1)
            return 11'(`VGC_COL_STEP * i);
        else if (i == `VGC_GAP1_COL)
            return 11'(`VGC_GAP1_POS);
        else if (i < `VGC_GAP2_COL)
            return 11'(`VGC_SEG2_POS + `VGC_COL_STEP * (i - `VGC_SEG2_COL));
        else if (i == `VGC_GAP2_COL)
            return 11'(`VGC_GAP2_POS);
        else if (i < `VGC_LAST_COL)
            return 11'(`VGC_SEG3_POS + `VGC_COL_STEP * (i - `VGC_SEG3_COL));
        else
            return 11'(`VGC_LAST_POS);
    endfunction

    function automatic logic [Y_W:0] row_pos(input int k);
        return (Y_W+1)'((FS * (`VGC_LO_PCT + `VGC_STEP_PCT * k)) / 100);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input buffer and cell location

    logic [PW-1:0] fifo_data;
    logic fifo_valid;
    logic adv;
    logic take;

    vgc_fifo #(.W(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(pt_valid),
        .in_ready(pt_ready),
        .in_data({pt_x, pt_y}),
        .out_valid(fifo_valid),
        .out_ready(adv),
        .out_data(fifo_data)
    );

    assign adv = !out_valid_ff || out_ready;
    assign take = adv && fifo_valid;

    logic [X_W-1:0] in_x;
    logic [Y_W-1:0] in_y;
    logic [10:0] xn;
    logic [10:0] last_pt;
    logic [4:0] col;
    logic [3:0] row;
    logic below;
    logic above;
    logic [8:0] t;
    logic [8:0] u;

    assign in_x = fifo_data[PW-1:Y_W];
    assign in_y = fifo_data[Y_W-1:0];

    always_comb
    begin
        logic [10:0] dx;
        logic [10:0] dxs;
        logic [Y_W:0] dy;
        logic [Y_W:0] dys;
        logic [19:0] tq;
        logic [19:0] uq;
        dx = '0;
        dxs = '0;
        dy = '0;
        dys = '0;
        tq = '0;
        uq = '0;
        // Record length scales x up onto the 1024-point table positions
        unique case (len_sel) // see RL12
            vgc_pkg::VGC_LEN_512:
            begin
                xn = {in_x[9:0], 1'b0};
                last_pt = 11'h1ff;
            end
            vgc_pkg::VGC_LEN_256:
            begin
                xn = {in_x[9:0], 1'b0} << 1;
                last_pt = 11'h0ff;
            end
            default:
            begin
                xn = {1'b0, in_x[9:0]};
                last_pt = 11'h3ff;
            end
        endcase
        if ({1'b0, in_x[9:0]} == last_pt)
            xn = 11'(`VGC_LAST_POS); // see RL13
        col = '0;
        for (int i = 1; i < `VGC_LAST_COL; i++)
            if (xn >= col_pos(i)) // see RL11, RL23
                col = 5'(i);
        row = '0;
        for (int k = 1; k < `VGC_ROWS - 1; k++)
            if ({1'b0, in_y} >= row_pos(k)) // see RL10, RL23
                row = 4'(k);
        below = {1'b0, in_y} < row_pos(0);
        above = {1'b0, in_y} > row_pos(`VGC_ROWS - 1);
        dx = xn - col_pos(int'(col));
        dxs = col_pos(int'(col) + 1) - col_pos(int'(col));
        tq = 20'({dx, 8'h00}) / 20'(dxs); // see RL3
        t = (tq > 20'(`VGC_FRAC_ONE)) ? `VGC_FRAC_ONE : tq[8:0];
        // Vertical divisor is the row spacing, not the column one
        dy = {1'b0, in_y} - row_pos(int'(row));
        dys = row_pos(int'(row) + 1) - row_pos(int'(row));
        uq = 20'({dy, 8'h00}) / 20'(dys);
        if (below)
            u = '0; // see RL7
        else if (above || uq > 20'(`VGC_FRAC_ONE))
            u = `VGC_FRAC_ONE; // see RL6
        else
            u = uq[8:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Stage one registers

    logic s1_valid_ff;
    logic s1_corr_ff;
    logic s1_lo_zero_ff;
    logic s1_hi_zero_ff;
    logic [X_W-1:0] s1_x_ff;
    logic [Y_W-1:0] s1_y_ff;
    logic [8:0] s1_base_ff;
    logic [8:0] s1_t_ff;
    logic [8:0] s1_u_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s1_valid_ff <= 1'b0;
        else if (adv)
            s1_valid_ff <= fifo_valid;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_corr_ff <= 1'b0;
            s1_lo_zero_ff <= 1'b0;
            s1_hi_zero_ff <= 1'b0;
            s1_x_ff <= '0;
            s1_y_ff <= '0;
            s1_base_ff <= '0;
            s1_t_ff <= '0;
            s1_u_ff <= '0;
        end
        else if (take)
        begin
            s1_corr_ff <= corr_en; // see RL14
            s1_lo_zero_ff <= above; // see RL6
            s1_hi_zero_ff <= below; // see RL7
            s1_x_ff <= in_x;
            s1_y_ff <= in_y;
            s1_base_ff <= 9'(row * `VGC_COLS + col); // see RL2
            s1_t_ff <= t;
            s1_u_ff <= u;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Correction table

    logic signed [15:0] tbl [`VGC_TBL_N]; // see RL8, RL21

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `VGC_TBL_N; i++)
                tbl[i] <= `VGC_TBL_RST;
        end
        else if (cal_wr && acq_running_ff && cal_addr < 9'(`VGC_TBL_N))
            tbl[cal_addr] <= cal_data;
    end

    vgc_pkg::vgc_cal_st_t cal_st_ff;
    assign acq_running_ff = (cal_st_ff == vgc_pkg::VGC_CAL_RUN);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cal_st_ff <= vgc_pkg::VGC_CAL_STOP;
        else
        begin
            unique case (cal_st_ff)
                vgc_pkg::VGC_CAL_STOP:
                    if (cal_start)
                        cal_st_ff <= vgc_pkg::VGC_CAL_RUN; // see RL15
                vgc_pkg::VGC_CAL_RUN:
                    if (cal_done && !cal_start)
                        cal_st_ff <= vgc_pkg::VGC_CAL_STOP;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tbl_rd_valid_ff <= 1'b0;
            tbl_rd_data_ff <= '0;
        end
        else
        begin
            tbl_rd_valid_ff <= tbl_rd_req;
            if (tbl_rd_req)
                tbl_rd_data_ff <= (tbl_rd_addr < 9'(`VGC_TBL_N)) ?
                    tbl[tbl_rd_addr] : '0; // see RL8
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bilinear interpolation and output

    logic signed [15:0] e_ll;
    logic signed [15:0] e_lr;
    logic signed [15:0] e_ur;
    logic signed [15:0] e_ul;
    logic signed [Y_W+1:0] corr_c;
    logic [Y_W-1:0] y_new;

    always_comb
    begin
        logic [17:0] w_ll;
        logic [17:0] w_lr;
        logic [17:0] w_ur;
        logic [17:0] w_ul;
        logic signed [37:0] acc;
        logic signed [37:0] rnd;
        logic signed [Y_W+2:0] ysum;
        w_ll = '0;
        w_lr = '0;
        w_ur = '0;
        w_ul = '0;
        acc = '0;
        rnd = '0;
        ysum = '0;
        e_ll = s1_lo_zero_ff ? '0 : tbl[s1_base_ff];
        e_lr = s1_lo_zero_ff ? '0 : tbl[9'(s1_base_ff + 9'h001)];
        e_ur = s1_hi_zero_ff ? '0 : tbl[9'(s1_base_ff + 9'(`VGC_COLS + 1))];
        e_ul = s1_hi_zero_ff ? '0 : tbl[9'(s1_base_ff + 9'(`VGC_COLS))];
        w_ll = (`VGC_FRAC_ONE - s1_t_ff) * (`VGC_FRAC_ONE - s1_u_ff);
        w_lr = s1_t_ff * (`VGC_FRAC_ONE - s1_u_ff);
        w_ur = s1_t_ff * s1_u_ff;
        w_ul = (`VGC_FRAC_ONE - s1_t_ff) * s1_u_ff;
        acc = e_ll * $signed({1'b0, w_ll}) + e_lr * $signed({1'b0, w_lr})
            + e_ur * $signed({1'b0, w_ur})
            + e_ul * $signed({1'b0, w_ul}); // see RL4
        // Fixed point holds t, u and the scale of 16 until one final shift
        rnd = acc + (38'sd1 <<< (2 * `VGC_FRAC_W + `VGC_SCALE_SH - 1));
        corr_c = (Y_W+2)'(rnd >>> (2 * `VGC_FRAC_W + `VGC_SCALE_SH));
        // see RL9, RL22
        ysum = $signed({2'b00, s1_y_ff}) + (Y_W+3)'(corr_c); // see RL5
        if (ysum < 0)
            y_new = '0;
        else if (ysum > (Y_W+3)'(FS - 1))
            y_new = '1;
        else
            y_new = ysum[Y_W-1:0];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_valid_ff <= 1'b0;
            out_x_ff <= '0;
            out_y_ff <= '0;
        end
        else if (adv)
        begin
            // Only centroided points enter this path
            out_valid_ff <= s1_valid_ff; // see RL1, RL20
            out_x_ff <= s1_x_ff; // see RL5
            out_y_ff <= s1_corr_ff ? y_new : s1_y_ff; // see RL14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Defect list and removal ahead of centroiding

    logic [DEF_N-1:0] def_used_ff;
    logic [X_W-1:0] def_x_ff [DEF_N];
    logic [Y_W-1:0] def_y_ff [DEF_N];
    logic [DEF_N-1:0] def_hit;

    for (genvar g = 0; g < DEF_N; g++)
    begin : g_def
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                def_used_ff[g] <= 1'b0;
                def_x_ff[g] <= '0;
                def_y_ff[g] <= '0;
            end
            else if (def_wr && def_idx == g)
            begin
                def_used_ff[g] <= 1'b1;
                def_x_ff[g] <= def_x;
                def_y_ff[g] <= def_y;
            end
            else if (def_clear)
                def_used_ff[g] <= 1'b0;
        end
        assign def_hit[g] = def_used_ff[g] && def_x_ff[g] == tgt_line
            && def_y_ff[g] == tgt_row;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tgt_valid_ff <= 1'b0;
            tgt_charge_ff <= '0;
            tgt_void_ff <= 1'b0;
        end
        else
        begin
            tgt_valid_ff <= tgt_valid;
            if (tgt_valid)
            begin
                // Void marks the sample for the centroid gap filler
                tgt_void_ff <= defect_en && |def_hit; // see RL18
                tgt_charge_ff <= (defect_en && |def_hit) ? '0 : tgt_charge;
                // see RL17
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            def_rd_valid_ff <= 1'b0;
            def_rd_hit_ff <= 1'b0;
            def_rd_x_ff <= '0;
            def_rd_y_ff <= '0;
        end
        else
        begin
            def_rd_valid_ff <= def_rd_req;
            if (def_rd_req)
            begin
                def_rd_hit_ff <= def_used_ff[def_rd_idx]; // see RL19
                def_rd_x_ff <= def_x_ff[def_rd_idx];
                def_rd_y_ff <= def_y_ff[def_rd_idx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_start;
        cal_start && !acq_running_ff;
    endsequence
    sequence s_pass;
        adv && s1_valid_ff && !s1_corr_ff;
    endsequence
    property p_run;
        s_start |=> acq_running_ff;
    endproperty
    a_run: assert property (p_run) else $error("no run"); // see RL15
    property p_bypass;
        s_pass |=> out_valid_ff && out_y_ff == $past(s1_y_ff);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass"); // see RL14
    property p_xkeep;
        adv && s1_valid_ff |=> out_x_ff == $past(s1_x_ff);
    endproperty
    a_xkeep: assert property (p_xkeep) else $error("x moved"); // see RL5
    property p_hold;
        out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_y_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("lost"); // see RL1
    property p_last;
        fifo_valid && {1'b0, in_x} == last_pt |-> col == 5'd27;
    endproperty
    a_last: assert property (p_last) else $error("last col"); // see RL13
    property p_hi;
        s1_lo_zero_ff |-> e_ll == 0 && e_lr == 0;
    endproperty
    a_hi: assert property (p_hi) else $error("hi corners"); // see RL6
    property p_lo;
        s1_hi_zero_ff |-> e_ur == 0 && e_ul == 0;
    endproperty
    a_lo: assert property (p_lo) else $error("lo corners"); // see RL7
    property p_void;
        tgt_valid && defect_en && |def_hit |=> tgt_void_ff
            && tgt_charge_ff == 0;
    endproperty
    a_void: assert property (p_void) else $error("defect"); // see RL17
    property p_rd;
        tbl_rd_req && tbl_rd_addr < 9'd290 |=> tbl_rd_valid_ff
            && tbl_rd_data_ff == $past(tbl[tbl_rd_addr]);
    endproperty
    a_rd: assert property (p_rd) else $error("table read"); // see RL8
endmodule

// ---- rtl/vgc_consts.svh ----
`ifndef VGC_CONSTS_SVH
`define VGC_CONSTS_SVH
// Correction table shape
`define VGC_ROWS 10
`define VGC_COLS 29
`define VGC_TBL_N 290
`define VGC_TBL_RST 16'sh0000
// Stored constants are sixteen times the true correction
`define VGC_SCALE_SH 4
// Fixed point fractions t and u
`define VGC_FRAC_W 8
`define VGC_FRAC_ONE 9'h100
// Row placement in percent of full scale
`define VGC_LO_PCT 5
`define VGC_STEP_PCT 10
`define VGC_HI_PCT 95
// Column placement on a 1024-point record
`define VGC_COL_STEP 32
`define VGC_GAP1_COL 9
`define VGC_GAP1_POS 320
`define VGC_SEG2_COL 10
`define VGC_SEG2_POS 384
`define VGC_GAP2_COL 19
`define VGC_GAP2_POS 704
`define VGC_SEG3_COL 20
`define VGC_SEG3_POS 768
`define VGC_LAST_COL 28
`define VGC_LAST_POS 1023
`endif

// ---- rtl/vgc_pkg.sv ----
package vgc_pkg;
    typedef enum logic [1:0] {
        VGC_LEN_1024 = 2'b00,
        VGC_LEN_512 = 2'b01,
        VGC_LEN_256 = 2'b10
    } vgc_len_t;
    typedef enum logic {
        VGC_CAL_STOP = 1'b0,
        VGC_CAL_RUN = 1'b1
    } vgc_cal_st_t;
endpackage

// ---- rtl/vgc_fifo.sv ----
`timescale 1ns/100ps
module vgc_fifo #(
    parameter int W = 21,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;
    logic ready_ff;

    assign in_ready = ready_ff;
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ready_ff <= 1'b1;
        else if (push && !pop)
            ready_ff <= count_ff != (AW+1)'(DEPTH-1);
        else if (pop && !push)
            ready_ff <= 1'b1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            if (push && !pop)
                count_ff <= count_ff + 1'b1;
            else if (pop && !push)
                count_ff <= count_ff - 1'b1;
        end
    end
endmodule

// ---- tb/vgc_host.sv ----
`timescale 1ns/100ps
module vgc_host (
    input wire logic clk,
    output logic pt_valid,
    input wire logic pt_ready,
    output logic [9:0] pt_x,
    output logic [10:0] pt_y,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [9:0] out_x,
    input wire logic [10:0] out_y
);
    logic stall;
    logic [20:0] got_q[$];

    initial
    begin
        pt_valid = 1'b0;
        pt_x = 10'h000;
        pt_y = 11'h000;
        out_ready = 1'b0;
        stall = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Downstream may stall at any time
    always @(posedge clk)
        out_ready <= !stall;

    always @(posedge clk)
        if (out_valid === 1'b1 && out_ready)
            got_q.push_back({out_x, out_y});

    ////////////////////////////////////////////////////////////////////////
    // Offers only finished centroid points
    task automatic send(input logic [9:0] x, input logic [10:0] y,
                        input int lim, output bit ok);
        int n;
        pt_valid <= 1'b1;
        pt_x <= x;
        pt_y <= y;
        n = 0;
        @(negedge clk);
        while (pt_ready !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        ok = (pt_ready === 1'b1);
        @(posedge clk);
    endtask

    // Released lines flip so stale data never looks valid
    task automatic idle();
        pt_valid <= 1'b0;
        pt_x <= ~pt_x;
        pt_y <= ~pt_y;
        @(posedge clk);
    endtask
endmodule

// ---- tb/vertical_geometry_correction_tb.sv ----
`timescale 1ns/100ps
module vertical_geometry_correction_tb;
    logic clk, rstn, corr_en, pt_valid, pt_ready, out_valid, out_ready;
    vgc_pkg::vgc_len_t len_sel;
    logic [9:0] pt_x, out_x, def_x, tgt_line, def_rd_x;
    logic [10:0] pt_y, out_y, def_y, tgt_row, def_rd_y;
    logic cal_start, cal_done, cal_wr, acq_run, tbl_rd_req, tbl_rd_valid;
    logic [8:0] cal_addr, tbl_rd_addr;
    logic signed [15:0] cal_data, tbl_rd_data;
    logic defect_en, def_clear, def_wr, def_rd_req, def_rd_valid, def_rd_hit;
    logic [2:0] def_idx, def_rd_idx;
    logic tgt_valid, tgt_valid_o, tgt_void;
    logic [7:0] tgt_charge, tgt_charge_o;
    int n_fail = 0;
    int comparisons = 0;

    vgc_core i_dut (.clk(clk), .rstn(rstn), .corr_en(corr_en),
        .len_sel(len_sel), .pt_valid(pt_valid), .pt_ready(pt_ready),
        .pt_x(pt_x), .pt_y(pt_y), .out_valid_ff(out_valid),
        .out_ready(out_ready), .out_x_ff(out_x), .out_y_ff(out_y),
        .cal_start(cal_start), .cal_done(cal_done), .cal_wr(cal_wr),
        .cal_addr(cal_addr), .cal_data(cal_data), .acq_running_ff(acq_run),
        .tbl_rd_req(tbl_rd_req), .tbl_rd_addr(tbl_rd_addr),
        .tbl_rd_valid_ff(tbl_rd_valid), .tbl_rd_data_ff(tbl_rd_data),
        .defect_en(defect_en), .def_clear(def_clear), .def_wr(def_wr),
        .def_idx(def_idx), .def_x(def_x), .def_y(def_y),
        .def_rd_req(def_rd_req), .def_rd_idx(def_rd_idx),
        .def_rd_valid_ff(def_rd_valid), .def_rd_hit_ff(def_rd_hit),
        .def_rd_x_ff(def_rd_x), .def_rd_y_ff(def_rd_y),
        .tgt_valid(tgt_valid), .tgt_line(tgt_line), .tgt_row(tgt_row),
        .tgt_charge(tgt_charge), .tgt_valid_ff(tgt_valid_o),
        .tgt_charge_ff(tgt_charge_o), .tgt_void_ff(tgt_void));

    vgc_host i_host (.clk(clk), .pt_valid(pt_valid), .pt_ready(pt_ready),
        .pt_x(pt_x), .pt_y(pt_y), .out_valid(out_valid),
        .out_ready(out_ready), .out_x(out_x), .out_y(out_y));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tbl_wr(input int a, input int d);
        cal_wr <= 1'b1;
        cal_addr <= a[8:0];
        cal_data <= d[15:0];
        @(posedge clk);
        cal_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic tbl_rd(input int a, input int e);
        tbl_rd_req <= 1'b1;
        tbl_rd_addr <= a[8:0];
        @(posedge clk);
        tbl_rd_req <= 1'b0;
        @(negedge clk);
        chk(tbl_rd_valid, 1);
        chk({{16{tbl_rd_data[15]}}, tbl_rd_data}, e);
        @(posedge clk);
    endtask

    task automatic pt(input int x, input int y, input int e);
        bit ok;
        int n;
        logic [20:0] v;
        i_host.send(x[9:0], y[10:0], 2000, ok);
        i_host.idle();
        n = 0;
        while (i_host.got_q.size() == 0 && n < 60)
        begin
            @(posedge clk);
            n++;
        end
        chk(i_host.got_q.size(), 1);
        if (i_host.got_q.size() > 0)
        begin
            v = i_host.got_q.pop_front();
            chk(v[20:11], x);
            chk(v[10:0], e);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(acq_run, 0);
        chk(out_valid, 0);
        chk(pt_ready, 1);
        tbl_rd(61, 0);
    endtask

    // Row-major cells: addr = row * 29 + col
    task automatic t_cal();
        int wa[11] = '{61, 62, 3, 32, 264, 235, 86, 289, 28, 57, 290};
        int wd[11] = '{24, -56, 160, 800, -160, 800, 48, 64, -64, 0, 77};
        tbl_wr(61, 999);
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        @(posedge clk);
        chk(acq_run, 1);
        foreach (wa[i])
            tbl_wr(wa[i], wd[i]);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
        @(posedge clk);
        chk(acq_run, 0);
        tbl_wr(61, 999);
        for (int i = 0; i < 10; i++)
            tbl_rd(wa[i], wd[i]);
        tbl_rd(290, 0);
    endtask

    // Stored 16x: 24 -> 1.5 -> 2, -56 -> -3.5 -> -3
    task automatic t_interp();
        corr_en <= 1'b1;
        len_sel <= vgc_pkg::VGC_LEN_1024;
        pt(96, 512, 514);
        pt(112, 512, 511);
        pt(128, 512, 509);
        pt(1023, 512, 515);
    endtask

    task automatic t_len();
        len_sel <= vgc_pkg::VGC_LEN_512;
        t_cal();
        pt(48, 512, 514);
        pt(56, 512, 511);
        pt(511, 512, 515);
        len_sel <= vgc_pkg::VGC_LEN_256;
        t_cal();
        pt(24, 512, 514);
        pt(28, 512, 511);
        pt(255, 512, 515);
        len_sel <= vgc_pkg::VGC_LEN_1024;
    endtask

    task automatic t_edges();
        pt(96, 2000, 1990);
        pt(96, 50, 60);
        pt(1023, 2047, 2047);
        pt(1023, 0, 0);
    endtask

    task automatic t_off();
        corr_en <= 1'b0;
        pt(96, 512, 512);
        pt(96, 2000, 2000);
    endtask

    // Stalled sink: FIFO must refuse, then drain in order
    task automatic t_fifo();
        int acc;
        int n;
        bit ok;
        logic [20:0] v;
        i_host.stall <= 1'b1;
        acc = 0;
        ok = 1'b1;
        while (ok && acc < 16)
        begin
            i_host.send(acc[9:0], 11'h064 + acc[10:0], 0, ok);
            if (ok)
                acc++;
        end
        i_host.idle();
        chk(acc, 10);
        chk(pt_ready, 0);
        i_host.stall <= 1'b0;
        n = 0;
        while (i_host.got_q.size() < acc && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk(i_host.got_q.size(), acc);
        for (int i = 0; i < acc && i_host.got_q.size() > 0; i++)
        begin
            v = i_host.got_q.pop_front();
            chk(v, {i[9:0], 11'h064 + i[10:0]});
        end
        chk(pt_ready, 1);
    endtask

    task automatic tgt(input int ln, input int e, input int vd);
        tgt_valid <= 1'b1;
        tgt_line <= ln[9:0];
        tgt_row <= 11'h258;
        tgt_charge <= 8'h5a;
        @(posedge clk);
        tgt_valid <= 1'b0;
        tgt_line <= ~tgt_line;
        tgt_row <= ~tgt_row;
        @(negedge clk);
        chk(tgt_valid_o, 1);
        chk(tgt_charge_o, e);
        chk(tgt_void, vd);
        @(posedge clk);
    endtask

    task automatic def_rd(input int i, input int h);
        def_rd_req <= 1'b1;
        def_rd_idx <= i[2:0];
        @(posedge clk);
        def_rd_req <= 1'b0;
        @(negedge clk);
        chk(def_rd_valid, 1);
        chk(def_rd_hit, h);
        if (h == 1)
            chk({def_rd_x, def_rd_y}, {10'h028, 11'h258});
        @(posedge clk);
    endtask

    task automatic t_defect();
        def_wr <= 1'b1;
        def_idx <= 3'h2;
        def_x <= 10'h028;
        def_y <= 11'h258;
        @(posedge clk);
        def_wr <= 1'b0;
        defect_en <= 1'b1;
        tgt(40, 0, 1);
        tgt(41, 8'h5a, 0);
        def_rd(2, 1);
        def_rd(3, 0);
        defect_en <= 1'b0;
        tgt(40, 8'h5a, 0);
        def_clear <= 1'b1;
        @(posedge clk);
        def_clear <= 1'b0;
        def_rd(2, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        corr_en = 1'b0;
        len_sel = vgc_pkg::VGC_LEN_1024;
        {cal_start, cal_done, cal_wr, tbl_rd_req} = 4'h0;
        cal_addr = 9'h000;
        cal_data = 16'sh0000;
        tbl_rd_addr = 9'h000;
        {defect_en, def_clear, def_wr, def_rd_req, tgt_valid} = 5'h00;
        {def_idx, def_rd_idx} = 6'h00;
        {def_x, def_y, tgt_line, tgt_row, tgt_charge} = 50'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_cal();
        t_interp();
        t_len();
        t_edges();
        t_off();
        t_fifo();
        t_defect();
        close_out();
    end

    // Whole run needs about 300 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule
